// file: src/uhp_defs.svh
// offsets, field positions and report constants of the hid packetizer
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef UHP_DEFS_SVH
`define UHP_DEFS_SVH

// ************************************
// register offsets
// ************************************
`define UHP_OFF_CTRL       8'h00
`define UHP_OFF_STATUS     8'h04
`define UHP_OFF_INT_STAT   8'h08
`define UHP_OFF_INT_MASK   8'h0c
`define UHP_OFF_ID_OVR     8'h10
`define UHP_OFF_STR_PTR    8'h14
`define UHP_OFF_RX_REL     8'h18
`define UHP_OFF_TX_CTRL    8'h1c
`define UHP_OFF_RX_DATA    8'h40
`define UHP_OFF_TX_DATA    8'h60

// ************************************
// field positions
// ************************************
`define UHP_CTRL_USB_EN    0
`define UHP_CTRL_ID_CUST   1
`define UHP_CTRL_DPHASE    2
`define UHP_CTRL_STR_CUST  3
`define UHP_INT_RX_CMD     0
`define UHP_INT_RX_DATA    1
`define UHP_INT_ABORT      2
`define UHP_INT_BAD        3
`define UHP_INT_IGNORED    4
`define UHP_INT_TX_DONE    5
`define UHP_INT_W          6
`define UHP_TX_KIND        8
`define UHP_TX_GO          31

// ************************************
// report layout and endpoints
// ************************************
`define UHP_ID_CMD_OUT     8'h01
`define UHP_ID_DATA_OUT    8'h02
`define UHP_ID_CMD_IN      8'h03
`define UHP_ID_DATA_IN     8'h04
`define UHP_HDR_BYTES      6'd3
`define UHP_MAX_PKT        32
`define UHP_MAX_RPT        35
`define UHP_RPT_COUNT      8'h22
`define UHP_RPT_SIZE       8'h08
`define UHP_LOG_MAX        8'hff
`define UHP_EP_CTRL        4'h0
`define UHP_EP_IN          4'h1
`define UHP_EP_OUT         4'h2
`define UHP_LANG_ID        16'h0409
`define UHP_DESC_ITEM_LEN  7'd17
`define UHP_DESC_LEN       7'd68

`endif

// file: src/uhp_pkg.sv
// types shared by the hid packetizer modules
// assumes uhp_defs.svh for all numeric constants
package uhp_pkg;
  typedef logic [7:0] uhp_byte_t;
  typedef enum logic [0:0] {UHP_TX_IDLE, UHP_TX_SEND} uhp_tx_state_e;
endpackage

// file: src/uhp_report_rx.sv
// inbound report parser: id, little-endian length, packet bytes into a buffer
// assumes bytes arrive from the usb engine on the same clock, one per valid
`include "uhp_defs.svh"
module uhp_report_rx import uhp_pkg::*; #(
  parameter int MAX_PKT = `UHP_MAX_PKT,
  parameter int MAX_RPT = `UHP_MAX_RPT
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        byte_valid,
  input  wire uhp_byte_t   byte_data,
  input  wire logic        byte_last,
  input  wire logic        accept_en,
  output logic             done,
  output uhp_byte_t        done_id,
  output logic [15:0]      done_len,
  output logic             done_bad,
  input  wire logic [2:0]  rd_idx,
  output logic [31:0]      rd_word
);
  // ************************************
  // byte counting
  // ************************************
  uhp_byte_t   mem [MAX_PKT];
  logic [5:0]  cnt;
  logic        drop;
  logic        over;
  logic [15:0] len;

  wire         first      = byte_valid && (cnt == 6'd0);
  wire         is_payload = byte_valid && (cnt >= `UHP_HDR_BYTES);
  wire  [5:0]  pidx       = cnt - `UHP_HDR_BYTES;
  wire         in_room    = pidx < 6'(MAX_PKT);
  wire         too_long   = cnt >= 6'(MAX_RPT);
  wire  [15:0] eff_len    = (cnt == 6'd2) ? {byte_data, len[7:0]} : len;
  wire  [15:0] carried    = (cnt >= 6'd2) ? 16'(cnt - 6'd2) : 16'h0000;
  wire         next_bad   = over || too_long || (cnt < 6'd2) ||
                            (eff_len > 16'(MAX_PKT)) || (eff_len > carried);
  wire  [5:0]  next_cnt   = too_long ? cnt : cnt + 6'd1;

  // ************************************
  // packet buffer
  // ************************************
  always_ff @(posedge clk) begin
    if (is_payload && in_room && !drop)
      mem[pidx[4:0]] <= byte_data;
  end

  assign rd_word = {mem[{rd_idx, 2'b11}], mem[{rd_idx, 2'b10}],
                    mem[{rd_idx, 2'b01}], mem[{rd_idx, 2'b00}]};

  // ************************************
  // header capture and report end
  // ************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 6'd0;
      drop     <= 1'b0;
      over     <= 1'b0;
      len      <= 16'h0000;
      done     <= 1'b0;
      done_id  <= 8'h00;
      done_len <= 16'h0000;
      done_bad <= 1'b0;
    end else begin
      done <= 1'b0;
      if (byte_valid) begin
        if (first) begin
          drop    <= !accept_en;
          over    <= 1'b0;
          done_id <= byte_data;
        end
        if (cnt == 6'd1)
          len[7:0] <= byte_data;
        if (cnt == 6'd2)
          len[15:8] <= byte_data;
        if (too_long)
          over <= 1'b1;
        if (byte_last) begin
          cnt      <= 6'd0;
          done     <= !(first ? !accept_en : drop);
          done_len <= eff_len;
          done_bad <= next_bad;
        end else begin
          cnt <= next_cnt;
        end
      end
    end
  end
endmodule

// file: src/uhp_top.sv
// usb hid report packetizer, device side, with a wishbone register slave
// assumes a usb engine on clk presenting endpoint bytes and in tokens
`include "uhp_defs.svh"
module uhp_top import uhp_pkg::*; #(
  parameter logic [15:0] DEFAULT_VID = 16'h1234, // arbitrary value
  parameter logic [15:0] DEFAULT_PID = 16'h5678, // arbitrary value
  parameter logic [31:0] DEFAULT_STR = 32'h0000_0000,
  parameter int          MAX_PKT     = `UHP_MAX_PKT
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  input  wire logic        out_valid,
  input  wire logic [3:0]  out_ep,
  input  wire uhp_byte_t   out_data,
  input  wire logic        out_last,
  output logic             out_nak,
  input  wire logic        in_token,
  input  wire logic [3:0]  in_ep,
  output logic             in_nak,
  output logic             in_valid,
  output uhp_byte_t        in_data,
  output logic             in_last,
  input  wire logic        in_ready,
  input  wire logic [6:0]  rdesc_index,
  output uhp_byte_t        rdesc_byte,
  input  wire logic [7:0]  str_index,
  output logic [1:0]       str_role,
  output logic             str_valid,
  output logic [15:0]      lang_id,
  output logic [15:0]      vendor_id,
  output logic [15:0]      product_id,
  output logic [31:0]      string_table_pointer,
  output logic             usb_clock_source_select,
  output logic             internal_osc_enable,
  output logic             clock_recovery_enable
);
  // ************************************
  // functions
  // ************************************
  // one descriptor item per report id
  function automatic uhp_byte_t desc_byte(input logic [6:0] idx);
    logic [6:0] item;
    logic [6:0] off;
    item = idx / `UHP_DESC_ITEM_LEN;
    off  = idx % `UHP_DESC_ITEM_LEN;
    desc_byte = 8'h00;
    if (idx < `UHP_DESC_LEN) begin
      case (off)
        7'd0:    desc_byte = 8'h85;
        7'd1:    desc_byte = 8'(item + 7'd1);
        7'd2:    desc_byte = 8'h19;
        7'd3:    desc_byte = 8'h01;
        7'd4:    desc_byte = 8'h29;
        7'd5:    desc_byte = 8'h01;
        7'd6:    desc_byte = 8'h15;
        7'd7:    desc_byte = 8'h00;
        7'd8:    desc_byte = 8'h26;
        7'd9:    desc_byte = `UHP_LOG_MAX;
        7'd10:   desc_byte = 8'h00;
        7'd11:   desc_byte = 8'h75;
        7'd12:   desc_byte = `UHP_RPT_SIZE;
        7'd13:   desc_byte = 8'h95;
        7'd14:   desc_byte = `UHP_RPT_COUNT;
        7'd15:   desc_byte = (item < 7'd2) ? 8'h91 : 8'h81;
        default: desc_byte = 8'h02;
      endcase
    end
  endfunction

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    is_reg = (a[7:2] == off[7:2]);
  endfunction

  // ************************************
  // reset synchroniser
  // ************************************
  logic rst_s1;
  logic rst_sn;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_sn <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_sn <= rst_s1;
    end
  end

  // ************************************
  // registers and decode
  // ************************************
  logic [3:0]          ctrl;
  logic [`UHP_INT_W-1:0] int_stat;
  logic [`UHP_INT_W-1:0] int_mask;
  logic [15:0]         vendor_id_override;
  logic [15:0]         product_id_override;
  logic [31:0]         str_ptr;
  logic                rx_full;
  uhp_byte_t           rx_id;
  logic [5:0]          rx_len;
  logic [5:0]          tx_len;
  logic                tx_kind;
  logic                tx_pend;
  uhp_tx_state_e       tx_state;
  logic [5:0]          tidx;
  uhp_byte_t           tx_mem [MAX_PKT];
  logic [31:0]         rx_word;

  wire        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_wr    = wb_req && wb_we_i;
  wire        wr_ctrl  = wb_wr && is_reg(wb_adr_i, `UHP_OFF_CTRL);
  wire        wr_istat = wb_wr && is_reg(wb_adr_i, `UHP_OFF_INT_STAT);
  wire        wr_imask = wb_wr && is_reg(wb_adr_i, `UHP_OFF_INT_MASK);
  wire        wr_id    = wb_wr && is_reg(wb_adr_i, `UHP_OFF_ID_OVR);
  wire        wr_str   = wb_wr && is_reg(wb_adr_i, `UHP_OFF_STR_PTR);
  wire        wr_rel   = wb_wr && is_reg(wb_adr_i, `UHP_OFF_RX_REL) && wb_sel_i[0] &&
                         wb_dat_i[0];
  wire        wr_txc   = wb_wr && is_reg(wb_adr_i, `UHP_OFF_TX_CTRL) && wb_sel_i[3] &&
                         wb_dat_i[`UHP_TX_GO];
  wire        in_rxd   = wb_adr_i[7:5] == 3'(`UHP_OFF_RX_DATA >> 5);
  wire        in_txd   = wb_adr_i[7:5] == 3'(`UHP_OFF_TX_DATA >> 5);
  wire        tx_go    = wr_txc && !tx_pend && (wb_dat_i[5:0] <= 6'(MAX_PKT));
  wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                          {8{wb_sel_i[0]}}};

  // ************************************
  // inbound reports
  // ************************************
  logic        rx_done;
  uhp_byte_t   rx_done_id;
  logic [15:0] rx_done_len;
  logic        rx_done_bad;

  uhp_report_rx #(.MAX_PKT(MAX_PKT), .MAX_RPT(`UHP_MAX_RPT)) u_rx (
    .clk        (clk),
    .rst_n      (rst_sn),
    .byte_valid (out_valid && (out_ep == `UHP_EP_OUT)),
    .byte_data  (out_data),
    .byte_last  (out_last),
    .accept_en  (!rx_full && ctrl[`UHP_CTRL_USB_EN]),
    .done       (rx_done),
    .done_id    (rx_done_id),
    .done_len   (rx_done_len),
    .done_bad   (rx_done_bad),
    .rd_idx     (wb_adr_i[4:2]),
    .rd_word    (rx_word)
  );

  wire rx_ok    = rx_done && !rx_done_bad;
  wire got_cmd  = rx_ok && (rx_done_id == `UHP_ID_CMD_OUT);
  wire got_dat  = rx_ok && (rx_done_id == `UHP_ID_DATA_OUT) && ctrl[`UHP_CTRL_DPHASE];
  wire got_abt  = got_dat && (rx_done_len == 16'h0000);
  wire deliver  = got_cmd || (got_dat && !got_abt);
  wire ignored  = rx_ok && !got_cmd && !got_dat;
  wire tx_fin   = (tx_state == UHP_TX_SEND) && in_valid && in_ready && in_last;

  wire [`UHP_INT_W-1:0] int_ev = {tx_fin, ignored, rx_done && rx_done_bad, got_abt,
                                  got_dat && !got_abt, got_cmd};
  wire [`UHP_INT_W-1:0] w1c    = wr_istat ? wb_dat_i[`UHP_INT_W-1:0] : '0;
  wire [`UHP_INT_W-1:0] next_int_stat = (int_stat & ~w1c) | int_ev;

  // ************************************
  // control and status registers
  // ************************************
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      ctrl                <= 4'h0;
      int_stat            <= '0;
      int_mask            <= '0;
      vendor_id_override  <= 16'h0000;
      product_id_override <= 16'h0000;
      str_ptr             <= 32'h0000_0000;
      rx_full             <= 1'b0;
      rx_id               <= 8'h00;
      rx_len              <= 6'd0;
      tx_len              <= 6'd0;
      tx_kind             <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      if (got_abt)
        ctrl[`UHP_CTRL_DPHASE] <= 1'b0;
      if (wr_ctrl && wb_sel_i[0])
        ctrl <= wb_dat_i[3:0];
      if (wr_imask && wb_sel_i[0])
        int_mask <= wb_dat_i[`UHP_INT_W-1:0];
      if (wr_id)
        {product_id_override, vendor_id_override} <=
          ({product_id_override, vendor_id_override} & ~wmask) | (wb_dat_i & wmask);
      if (wr_str)
        str_ptr <= (str_ptr & ~wmask) | (wb_dat_i & wmask);
      if (wr_rel)
        rx_full <= 1'b0;
      if (deliver) begin
        rx_full <= 1'b1;
        rx_id   <= rx_done_id;
        rx_len  <= rx_done_len[5:0];
      end
      if (tx_go) begin
        tx_len  <= wb_dat_i[5:0];
        tx_kind <= wb_dat_i[`UHP_TX_KIND];
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (wb_wr && in_txd && wb_sel_i[i] && !tx_pend)
        tx_mem[{wb_adr_i[4:2], 2'(i)}] <= wb_dat_i[i*8 +: 8];
    end
  end

  // ************************************
  // wishbone read and acknowledge
  // ************************************
  wire [31:0] rd_data =
    is_reg(wb_adr_i, `UHP_OFF_CTRL)     ? {28'h0, ctrl} :
    is_reg(wb_adr_i, `UHP_OFF_STATUS)   ? {8'h0, rx_id, 2'b00, rx_len, 6'h0, tx_pend,
                                           rx_full} :
    is_reg(wb_adr_i, `UHP_OFF_INT_STAT) ? {26'h0, int_stat} :
    is_reg(wb_adr_i, `UHP_OFF_INT_MASK) ? {26'h0, int_mask} :
    is_reg(wb_adr_i, `UHP_OFF_ID_OVR)   ? {product_id_override, vendor_id_override} :
    is_reg(wb_adr_i, `UHP_OFF_STR_PTR)  ? str_ptr :
    is_reg(wb_adr_i, `UHP_OFF_TX_CTRL)  ? {23'h0, tx_kind, 2'b00, tx_len} :
    in_rxd                              ? rx_word :
                                          32'h0000_0000;

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq      <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
      irq      <= |(next_int_stat & int_mask);
    end
  end

  // ************************************
  // outbound reports on the in endpoint
  // ************************************
  wire       tok_ok   = in_token && (in_ep == `UHP_EP_IN);
  wire       start    = tok_ok && tx_pend && (tx_state == UHP_TX_IDLE);
  wire [5:0] last_idx = tx_len + 6'd2;
  wire [5:0] nidx     = tidx + 6'd1;
  wire [5:0] npos     = nidx - `UHP_HDR_BYTES;
  wire uhp_byte_t next_byte = (nidx == 6'd1) ? {2'b00, tx_len} :
                              (nidx == 6'd2) ? 8'h00 :
                                               tx_mem[npos[4:0]];
  wire uhp_byte_t tx_id     = tx_kind ? `UHP_ID_DATA_IN : `UHP_ID_CMD_IN;

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      tx_state <= UHP_TX_IDLE;
      tx_pend  <= 1'b0;
      tidx     <= 6'd0;
      in_valid <= 1'b0;
      in_data  <= 8'h00;
      in_last  <= 1'b0;
      in_nak   <= 1'b0;
    end else begin
      in_nak <= tok_ok && !start;
      if (tx_go)
        tx_pend <= 1'b1;
      case (tx_state)
        UHP_TX_IDLE: begin
          if (start) begin
            tx_state <= UHP_TX_SEND;
            tidx     <= 6'd0;
            in_valid <= 1'b1;
            in_data  <= tx_id;
            in_last  <= 1'b0;
          end
        end
        UHP_TX_SEND: begin
          if (in_valid && in_ready) begin
            if (in_last) begin
              tx_state <= UHP_TX_IDLE;
              tx_pend  <= 1'b0;
              in_valid <= 1'b0;
              in_last  <= 1'b0;
            end else begin
              tidx    <= nidx;
              in_data <= next_byte;
              in_last <= (nidx == last_idx);
            end
          end
        end
        default: tx_state <= UHP_TX_IDLE;
      endcase
    end
  end

  // ************************************
  // descriptors, identity and clocking
  // ************************************
  wire       str_ok     = str_index <= 8'h03;
  wire [1:0] next_role  = str_index[1:0];

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      out_nak                 <= 1'b1;
      rdesc_byte              <= 8'h00;
      str_role                <= 2'b00;
      str_valid               <= 1'b0;
      lang_id                 <= `UHP_LANG_ID;
      vendor_id               <= DEFAULT_VID;
      product_id              <= DEFAULT_PID;
      string_table_pointer    <= DEFAULT_STR;
      usb_clock_source_select <= 1'b0;
      internal_osc_enable     <= 1'b0;
      clock_recovery_enable   <= 1'b0;
    end else begin
      out_nak    <= rx_full || deliver || !ctrl[`UHP_CTRL_USB_EN];
      rdesc_byte <= desc_byte(rdesc_index);
      str_role   <= next_role;
      str_valid  <= str_ok;
      lang_id    <= `UHP_LANG_ID;
      vendor_id  <= ctrl[`UHP_CTRL_ID_CUST] ? vendor_id_override : DEFAULT_VID;
      product_id <= ctrl[`UHP_CTRL_ID_CUST] ? product_id_override : DEFAULT_PID;
      string_table_pointer <= ctrl[`UHP_CTRL_STR_CUST] ? str_ptr : DEFAULT_STR;
      usb_clock_source_select <= ctrl[`UHP_CTRL_USB_EN];
      internal_osc_enable     <= ctrl[`UHP_CTRL_USB_EN];
      clock_recovery_enable   <= ctrl[`UHP_CTRL_USB_EN];
    end
  end
endmodule

// file: test/uhp_top_sva.sv
// port checker of the hid packetizer
// assumes binding onto uhp_top, one clock domain
module uhp_top_sva import uhp_pkg::*; (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        in_token,
  input wire logic [3:0]  in_ep,
  input wire logic        in_nak,
  input wire logic        in_valid,
  input wire uhp_byte_t   in_data,
  input wire logic        in_last,
  input wire logic        in_ready,
  input wire logic        out_nak,
  input wire logic [6:0]  rdesc_index,
  input wire uhp_byte_t   rdesc_byte,
  input wire logic [7:0]  str_index,
  input wire logic [1:0]  str_role,
  input wire logic        str_valid,
  input wire logic [15:0] lang_id,
  input wire logic        usb_clock_source_select,
  input wire logic        internal_osc_enable,
  input wire logic        clock_recovery_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // helpers: cycles since reset, in bytes taken
  // ****
  logic [1:0] up;
  logic [5:0] n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 2'h0;
      n  <= 6'h0;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (in_valid && in_ready) n <= in_last ? 6'h0 : n + 6'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (up != 2'h3);
  // ****
  // properties
  // ****
  sequence s_tok; in_token && in_ep == 4'h1; endsequence
  sequence s_stall; in_valid && !in_ready; endsequence
  property p_in_ans; s_tok |=> in_nak || in_valid; endproperty
  property p_in_hold; s_stall |=> in_valid && $stable(in_data) && $stable(in_last); endproperty
  property p_in_id; $rose(in_valid) |-> in_data == 8'h03 || in_data == 8'h04; endproperty
  property p_in_len; in_valid && in_ready |-> n < 6'h23 && (!in_last || n >= 6'h2); endproperty
  property p_desc; rdesc_index == 7'h0e |=> rdesc_byte == 8'h22; endproperty
  property p_desc_end; rdesc_index >= 7'h44 |=> rdesc_byte == 8'h00; endproperty
  property p_str; str_index <= 8'h3 |=> str_valid && str_role == $past(str_index[1:0]); endproperty
  property p_clk;
    internal_osc_enable == usb_clock_source_select
      && clock_recovery_enable == internal_osc_enable && lang_id == 16'h0409;
  endproperty
  property p_nak; !internal_osc_enable && !$past(internal_osc_enable) |-> out_nak; endproperty
  a_in_ans: assert property (p_in_ans) else $error("in token unanswered");
  a_in_hold: assert property (p_in_hold) else $error("in byte moved");
  a_in_id: assert property (p_in_id) else $error("bad in id");
  a_in_len: assert property (p_in_len) else $error("bad in length");
  a_desc: assert property (p_desc) else $error("bad count item");
  a_desc_end: assert property (p_desc_end) else $error("bad desc end");
  a_str: assert property (p_str) else $error("bad string role");
  a_clk: assert property (p_clk) else $error("bad clock select");
  a_nak: assert property (p_nak) else $error("no nak when off");
endmodule

bind uhp_top uhp_top_sva u_sva (.clk, .rst_n, .in_token, .in_ep, .in_nak, .in_valid,
  .in_data, .in_last, .in_ready, .out_nak, .rdesc_index, .rdesc_byte, .str_index,
  .str_role, .str_valid, .lang_id, .usb_clock_source_select, .internal_osc_enable,
  .clock_recovery_enable);

// file: test/uhp_host.sv
// usb host side model: sends out reports, pulls in reports
// assumes the packetizer on the same clock
module uhp_host import uhp_pkg::*; (
  input  wire logic       clk,
  input  wire logic       out_nak,
  output logic            out_valid,
  output logic [3:0]      out_ep,
  output uhp_byte_t       out_data,
  output logic            out_last,
  output logic            in_token,
  output logic [3:0]      in_ep,
  input  wire logic       in_nak,
  input  wire logic       in_valid,
  input  wire logic       in_last,
  output logic            in_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    out_valid = 1'b0;
    out_ep    = 4'h0;
    out_data  = 8'h00;
    out_last  = 1'b0;
    in_token  = 1'b0;
    in_ep     = 4'h0;
    in_ready  = 1'b0;
  end
  task automatic send(input uhp_byte_t b[$], input logic [3:0] ep);
    while (out_nak !== 1'b0) @(posedge clk);
    foreach (b[i]) begin
      out_valid <= 1'b1;
      out_ep    <= ep;
      out_data  <= b[i];
      out_last  <= (i == b.size() - 1);
      @(posedge clk);
    end
    out_valid <= 1'b0;
    out_last  <= 1'b0;
    out_data  <= ~b[b.size() - 1];
  endtask
  // ready stalls at random until the last byte is taken
  task automatic pull(input logic [3:0] ep);
    int k;
    bit done;
    k = 0;
    done = 1'b0;
    in_token <= 1'b1;
    in_ep    <= ep;
    @(posedge clk);
    in_token <= 1'b0;
    in_ep    <= ~ep;
    do begin
      @(posedge clk);
      done = in_valid && in_ready && in_last;
      in_ready <= (done || in_nak) ? 1'b0 : 1'($urandom_range(2) != 0);
      k++;
    end while (!done && !in_nak && k < 200);
  endtask
endmodule

// file: test/tb_uhp_top.sv
// bench of the hid packetizer: wishbone, out and in reports
// assumes uhp_top, uhp_host and the bound checker
module tb_uhp_top;
  import uhp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] VID = 16'h1234; // arbitrary value
  localparam logic [15:0] PID = 16'h5678; // arbitrary value
  logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, str_valid;
  logic        out_valid, out_last, out_nak, in_token, in_nak, in_valid, in_last, in_ready;
  logic        usb_clock_source_select, internal_osc_enable, clock_recovery_enable;
  logic [7:0]  wb_adr_i, str_index;
  logic [3:0]  wb_sel_i, out_ep, in_ep;
  logic [31:0] wb_dat_i, wb_dat_o, string_table_pointer, v, exp_q[$];
  uhp_byte_t   out_data, in_data, rdesc_byte, in_q[$], pk[$];
  logic [6:0]  rdesc_index = 7'h00;
  logic [1:0]  str_role;
  logic [15:0] lang_id, vendor_id, product_id;
  logic [5:0]  msk;
  int          fail_count, check_count, n;
  uhp_top #(.DEFAULT_VID(VID), .DEFAULT_PID(PID)) uut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .out_valid,
    .out_ep, .out_data, .out_last, .out_nak, .in_token, .in_ep, .in_nak, .in_valid,
    .in_data, .in_last, .in_ready, .rdesc_index, .rdesc_byte, .str_index, .str_role,
    .str_valid, .lang_id, .vendor_id, .product_id, .string_table_pointer,
    .usb_clock_source_select, .internal_osc_enable, .clock_recovery_enable);
  uhp_host host (.clk, .out_nak, .out_valid, .out_ep, .out_data, .out_last, .in_token,
    .in_ep, .in_nak, .in_valid, .in_last, .in_ready);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // ****
  // result watcher
  // ****
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && !wb_we_i && wb_cyc_i)
      chk(wb_dat_o, exp_q.size() ? exp_q.pop_front() : 32'hx);
    if (in_valid === 1'b1 && in_ready)
      chk({24'h0, in_data}, {24'h0, in_q.size() ? in_q.pop_front() : 8'hx});
    rdesc_index <= 7'($urandom_range(80));
    str_index   <= 8'($urandom_range(5));
  end
  task automatic out_rpt(input logic [7:0] id, input int len, input int c, input logic [31:0] st);
    uhp_byte_t b[$];
    pk = {};
    repeat (c) pk.push_back(8'($urandom));
    b = {id, 8'(len), 8'(len >> 8), pk};
    host.send(b, 4'h2);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
    chk({31'h0, irq}, {31'h0, |(st[5:0] & msk)});
    rd(8'h08, st);
    wr(8'h08, 32'h3f);
  endtask
  task automatic got(input logic [7:0] id, input int len);
    chk({31'h0, out_nak}, 32'h1);
    rd(8'h04, {8'h0, id, 2'b0, 6'(len), 8'h01});
    for (int i = 0; i < len / 4; i++)
      rd(8'h40 + 8'(4 * i), {pk[4*i+3], pk[4*i+2], pk[4*i+1], pk[4*i]});
    wr(8'h18, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, out_nak}, 32'h0);
  endtask
  task automatic in_rpt(input logic kind, input int len);
    in_q = {kind ? 8'h04 : 8'h03, 8'(len), 8'h00};
    for (int w = 0; w < 8; w++) begin
      v = $urandom;
      wr(8'h60 + 8'(4 * w), v);
      for (int j = 0; j < 4; j++)
        if (4 * w + j < len) in_q.push_back(v[8*j +: 8]);
    end
    wr(8'h1c, {1'b1, 22'h0, kind, 2'b0, 6'(len)});
    host.pull(4'h1);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
    rd(8'h08, 32'h20);
    wr(8'h08, 32'h3f);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    str_index = 8'h00;
    msk = 6'h3f;
    void'($urandom(92321));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({vendor_id, product_id}, {VID, PID});
    chk({31'h0, out_nak}, 32'h1);
    rd(8'h00, 32'h0);
    rd(8'h30, 32'h0);
    wr(8'h0c, 32'h3f);
    wr(8'h00, 32'h5);
    repeat (2) @(posedge clk);
    chk({29'h0, usb_clock_source_select, internal_osc_enable, clock_recovery_enable}, 32'h7);
    host.pull(4'h1);
    v = $urandom;
    wr(8'h10, v);
    wr(8'h14, ~v);
    wr(8'h00, 32'hf);
    repeat (2) @(posedge clk);
    chk({product_id, vendor_id}, v);
    chk(string_table_pointer, ~v);
    rd(8'h10, v);
    rd(8'h14, ~v);
    for (int k = 0; k < 3; k++) begin
      n = k == 0 ? 32 : $urandom_range(31);
      out_rpt(8'h01, n, n, 32'h1);
      got(8'h01, n);
    end
    out_rpt(8'h01, 33, 33, 32'h8);
    out_rpt(8'h01, 5, 3, 32'h8);
    out_rpt(8'h02, 4, 4, 32'h2);
    got(8'h02, 4);
    out_rpt(8'h02, 0, 0, 32'h4);
    rd(8'h00, 32'hb);
    out_rpt(8'h02, 3, 3, 32'h10);
    out_rpt(8'h04, 2, 2, 32'h10);
    msk = 6'h3e;
    wr(8'h0c, 32'h3e);
    rd(8'h0c, 32'h3e);
    out_rpt(8'h01, 2, 2, 32'h1);
    got(8'h01, 2);
    in_rpt(1'b1, 32);
    in_rpt(1'b0, 0);
    in_rpt(1'b1, $urandom_range(1, 31));
    wr(8'h1c, 32'h8000_0021);
    rd(8'h04, 32'h0001_0200);
    wrap_up();
  end
endmodule
